// ===== afs_defs.svh
// Register offsets, field positions and reset values of the fault aggregator
`ifndef AFS_DEFS_SVH
`define AFS_DEFS_SVH
// ==========================================================
// Register byte offsets
`define AFS_OFF_CTRL     12'h000
`define AFS_OFF_LOW      12'h004
`define AFS_OFF_HIGH     12'h008
`define AFS_OFF_MODF     12'h00c
`define AFS_OFF_CHF      12'h010
`define AFS_OFF_PACK     12'h014
`define AFS_OFF_CHST     12'h040
`define AFS_CHST_MASK    12'hfc0
// ==========================================================
// Field positions
`define AFS_CTRL_WIRE_HI 1
`define AFS_CTRL_INT     2
`define AFS_MF_GROUP     15
`define AFS_MF_CALIB     10
`define AFS_MF_CALERR    9
`define AFS_CS_CALERR    7
`define AFS_CS_UNDER     6
`define AFS_CS_OVER      5
`define AFS_PK_UNDER_TOP 31
`define AFS_PK_OVER_TOP  30
// ==========================================================
// Values
`define AFS_ALL_ONES     16'hffff
`define AFS_LOW_RST      16'h8000
`define AFS_HIGH_RST     16'h7fff
`endif

// ===== afs_fault_aggregator.sv
// Fault and range status aggregation for a multi-channel analog input block
//
// Notes on behaviour
// (R1) Group fault bit 15 set whenever any channel fault vector bit is set.
// (R2) Calibrating bit 10 set while any channel calibrates; fault vector forced on.
// (R3) Calibration fault bit 9 set when any active channel reports a calibration error.
// (R4) Module fault word bits 11 to 14 stay zero.
// (R5) Channel n maps to bit n; 16, 8 or 4 active channels by wiring.
// (R6) During calibration vector shows ffff, 00ff or 000f by wiring format.
// (R7) Lost owner communication shows the vector as ffff in every format.
// (R8) Below or above range on a channel sets its vector bit.
// (R9) Integer mode reports all channels' range in one packed 32-bit word.
// (R10) Packed word: channel n below range at bit 31 minus 2n.
// (R11) Packed word: channel n above range at bit 30 minus 2n.
// (R12) Below-range flag when sample is at or below the low limit.
// (R13) Above-range flag when sample is at or above the high limit.
// (R14) Integer mode reports only range; no per-channel calibration error flag.
// (R15) Module calibration fault bit still works in integer mode.
// (R16) Eight-channel build: 8, 4 or 2 active channels from bit 0.
// (R17) Fault words are presented together with each forwarded channel sample.
// (R18) Per-channel status word carries range and calibration error indications.
// (R19) Bits of inactive channels read zero outside calibration and comm loss.
`timescale 1ns/1ps
`include "afs_defs.svh"

module afs_fault_aggregator
  import afs_pkg::*;
#(
  parameter int NCH = 16
) (
  input  wire logic        CLK_IN,
  input  wire logic        RSTN_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic [NCH-1:0] CAL_BUSY_IN,
  input  wire logic [NCH-1:0] CAL_ERR_IN,
  input  wire logic        COMM_LOST_IN,
  input  wire logic        SMP_VLD_IN,
  input  wire logic [3:0]  SMP_CH_IN,
  input  wire logic [15:0] SMP_DATA_IN,
  output logic             RPT_VLD_OUT,
  output logic      [3:0]  RPT_CH_OUT,
  output logic      [15:0] RPT_DATA_OUT,
  output logic      [15:0] MODULE_FAULT_OUT,
  output logic      [15:0] CHAN_FAULT_OUT,
  output logic      [31:0] PACKED_STATUS_OUT
);

  // ==========================================================
  // Helpers
  // Active channel count for a wiring format
  function automatic logic [4:0] act_cnt_f(input afs_wiring_type w);
    logic [4:0] n;
    n = 5'(NCH);
    unique case (w)
      AFS_WIRE_SE:     act_cnt_f = n;          // [R5] [R16]
      AFS_WIRE_DIFF:   act_cnt_f = n >> 1;     // [R5] [R16]
      AFS_WIRE_HSDIFF: act_cnt_f = n >> 2;     // [R5] [R16]
    endcase
  endfunction

  // Mask of active channels, starting at bit 0
  function automatic logic [15:0] act_mask_f(input afs_wiring_type w);
    act_mask_f = 16'((17'h1 << act_cnt_f(w)) - 17'h1); // [R6]
  endfunction

  // Address decode, shared by write enable and error answer
  function automatic logic addr_hit_f(input logic [11:0] a);
    addr_hit_f = (a == `AFS_OFF_CTRL) || (a == `AFS_OFF_LOW) ||
                 (a == `AFS_OFF_HIGH) || (a == `AFS_OFF_MODF) ||
                 (a == `AFS_OFF_CHF)  || (a == `AFS_OFF_PACK) ||
                 (((a & `AFS_CHST_MASK) == `AFS_OFF_CHST) && (int'(a[5:2]) < NCH));
  endfunction

  // ==========================================================
  // Declarations
  afs_wiring_type  wiring_q;
  logic            int_mode_q;
  logic [15:0]     low_q;
  logic [15:0]     high_q;
  logic [NCH-1:0]  cal_busy_m;
  logic [NCH-1:0]  cal_busy_s;
  logic [NCH-1:0]  cal_err_m;
  logic [NCH-1:0]  cal_err_s;
  logic            comm_m;
  logic            comm_s;
  logic [15:0]     below_q;
  logic [15:0]     above_q;
  logic [15:0]     act_mask;
  logic [4:0]      act_cnt;
  logic            cal_any;
  logic            calerr_any;
  logic            smp_in_act;
  logic [15:0]     chf_d;
  logic [15:0]     chf_q;
  logic [15:0]     modf_d;
  logic [15:0]     modf_q;
  logic [31:0]     pack_d;
  logic [31:0]     pack_q;
  logic [31:0]     rd_d;
  logic [31:0]     rd_q;
  logic            pready_q;
  logic            pslverr_q;
  logic            rpt_vld_q;
  logic [3:0]      rpt_ch_q;
  logic [15:0]     rpt_data_q;
  logic            apb_acc;
  logic            apb_wr;

  // ==========================================================
  // Pin synchronisers; first stage read only by the second
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      cal_busy_m <= '0;
      cal_busy_s <= '0;
      cal_err_m  <= '0;
      cal_err_s  <= '0;
      comm_m     <= 1'b0;
      comm_s     <= 1'b0;
    end else begin
      cal_busy_m <= CAL_BUSY_IN;
      cal_busy_s <= cal_busy_m;
      cal_err_m  <= CAL_ERR_IN;
      cal_err_s  <= cal_err_m;
      comm_m     <= COMM_LOST_IN;
      comm_s     <= comm_m;
    end
  end

  // ==========================================================
  // APB slave: one wait state, answer always from flip-flops
  assign apb_acc = PSEL_IN && PENABLE_IN && !pready_q;
  assign apb_wr  = PSEL_IN && PENABLE_IN && pready_q && PWRITE_IN &&
                   addr_hit_f(PADDR_IN);

  // Handshake and error answer
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      rd_q      <= '0;
    end else begin
      pready_q  <= apb_acc;
      pslverr_q <= apb_acc && !addr_hit_f(PADDR_IN);
      rd_q      <= (apb_acc && !PWRITE_IN) ? rd_d : '0;
    end
  end

  // Control and limit registers; an illegal wiring code is ignored
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      wiring_q   <= AFS_WIRE_SE;
      int_mode_q <= 1'b0;
      low_q      <= `AFS_LOW_RST;
      high_q     <= `AFS_HIGH_RST;
    end else if (apb_wr) begin
      if (PADDR_IN == `AFS_OFF_CTRL) begin
        if (PWDATA_IN[`AFS_CTRL_WIRE_HI:0] != 2'h3) begin
          wiring_q <= afs_wiring_type'(PWDATA_IN[`AFS_CTRL_WIRE_HI:0]);
        end
        int_mode_q <= PWDATA_IN[`AFS_CTRL_INT];
      end
      if (PADDR_IN == `AFS_OFF_LOW) begin
        low_q <= PWDATA_IN[15:0];
      end
      if (PADDR_IN == `AFS_OFF_HIGH) begin
        high_q <= PWDATA_IN[15:0];
      end
    end
  end

  // Read multiplexer; per-channel words only exist in floating mode
  always_comb begin
    logic [3:0] ci;
    ci   = PADDR_IN[5:2];
    rd_d = '0;
    if (PADDR_IN == `AFS_OFF_CTRL) begin
      rd_d = {29'h0, int_mode_q, wiring_q};
    end else if (PADDR_IN == `AFS_OFF_LOW) begin
      rd_d = {16'h0, low_q};
    end else if (PADDR_IN == `AFS_OFF_HIGH) begin
      rd_d = {16'h0, high_q};
    end else if (PADDR_IN == `AFS_OFF_MODF) begin
      rd_d = {16'h0, modf_q};
    end else if (PADDR_IN == `AFS_OFF_CHF) begin
      rd_d = {16'h0, chf_q};
    end else if (PADDR_IN == `AFS_OFF_PACK) begin
      rd_d = pack_q;
    end else if (((PADDR_IN & `AFS_CHST_MASK) == `AFS_OFF_CHST) && !int_mode_q &&
                 act_mask[ci]) begin
      rd_d[`AFS_CS_CALERR] = cal_err_s[ci];  // [R18]
      rd_d[`AFS_CS_UNDER]  = below_q[ci];    // [R18]
      rd_d[`AFS_CS_OVER]   = above_q[ci];    // [R18]
    end
  end

  // ==========================================================
  // Range detection on the sample stream
  assign act_cnt    = act_cnt_f(wiring_q);
  assign act_mask   = act_mask_f(wiring_q);
  assign smp_in_act = {1'b0, SMP_CH_IN} < act_cnt;

  // Limits are inclusive, signed sample codes
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      below_q <= '0;
      above_q <= '0;
    end else if (SMP_VLD_IN && smp_in_act) begin
      below_q[SMP_CH_IN] <= $signed(SMP_DATA_IN) <= $signed(low_q);  // [R12]
      above_q[SMP_CH_IN] <= $signed(SMP_DATA_IN) >= $signed(high_q); // [R13]
    end
  end

  // ==========================================================
  // Fault words
  assign cal_any    = |cal_busy_s;
  assign calerr_any = |(cal_err_s & act_mask[NCH-1:0]);

  // Priority: comm loss, then calibration, then live range flags
  always_comb begin
    if (comm_s) begin
      chf_d = `AFS_ALL_ONES;                    // [R7]
    end else if (cal_any) begin
      chf_d = act_mask;                         // [R2] [R6]
    end else begin
      chf_d = (below_q | above_q) & act_mask;   // [R8] [R19]
    end
  end

  // Summary word; unused bits stay zero
  always_comb begin
    modf_d                 = '0;                // [R4]
    modf_d[`AFS_MF_GROUP]  = |chf_d;            // [R1]
    modf_d[`AFS_MF_CALIB]  = cal_any;           // [R2]
    modf_d[`AFS_MF_CALERR] = calerr_any;        // [R3] [R15]
  end

  // Packed range word, integer mode only
  always_comb begin
    pack_d = '0;
    if (int_mode_q) begin
      for (int i = 0; i < NCH; i++) begin
        pack_d[`AFS_PK_UNDER_TOP - 2 * i] = below_q[i] & act_mask[i]; // [R9] [R10] [R14]
        pack_d[`AFS_PK_OVER_TOP - 2 * i]  = above_q[i] & act_mask[i]; // [R9] [R11] [R19]
      end
    end
  end

  // Word registers
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      chf_q  <= '0;
      modf_q <= '0;
      pack_q <= '0;
    end else begin
      chf_q  <= chf_d;
      modf_q <= modf_d;
      pack_q <= pack_d;
    end
  end

  // Sample forwarding; the words stand beside each forwarded sample
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      rpt_vld_q  <= 1'b0;
      rpt_ch_q   <= '0;
      rpt_data_q <= '0;
    end else begin
      rpt_vld_q  <= SMP_VLD_IN;    // [R17]
      rpt_ch_q   <= SMP_CH_IN;
      rpt_data_q <= SMP_DATA_IN;
    end
  end

  // ==========================================================
  // Outputs
  assign PRDATA_OUT        = rd_q;
  assign PREADY_OUT        = pready_q;
  assign PSLVERR_OUT       = pslverr_q;
  assign RPT_VLD_OUT       = rpt_vld_q;
  assign RPT_CH_OUT        = rpt_ch_q;
  assign RPT_DATA_OUT      = rpt_data_q;
  assign MODULE_FAULT_OUT  = modf_q;
  assign CHAN_FAULT_OUT    = chf_q;
  assign PACKED_STATUS_OUT = pack_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);

  sequence s_low_hit;
    SMP_VLD_IN && smp_in_act && ($signed(SMP_DATA_IN) <= $signed(low_q));
  endsequence

  sequence s_high_hit;
    SMP_VLD_IN && smp_in_act && ($signed(SMP_DATA_IN) >= $signed(high_q));
  endsequence

  a_group_fault_sum: assert property (modf_q[`AFS_MF_GROUP] == |chf_q) // [R1]
    else $error("group fault bit disagrees with channel vector");

  a_cal_forces_mask: assert property ( // [R2]
    (cal_any && !comm_s) |=> (chf_q == $past(act_mask)) && modf_q[`AFS_MF_CALIB])
    else $error("calibration did not force the active mask");

  a_calerr_summary: assert property ( // [R3]
    1'b1 |=> modf_q[`AFS_MF_CALERR] == $past(calerr_any))
    else $error("calibration fault summary wrong");

  a_unused_bits: assert property ((modf_q[14:11] == 4'h0) && (modf_q[8:0] == 9'h0)) // [R4]
    else $error("unused module fault bits set");

  a_comm_all_ones: assert property (comm_s |=> chf_q == `AFS_ALL_ONES) // [R7]
    else $error("comm loss did not show all ones");

  a_low_to_vector: assert property ( // [R12]
    s_low_hit |=> below_q[$past(SMP_CH_IN)] ##1 chf_q[$past(SMP_CH_IN, 2)])
    else $error("below range sample did not reach the vector");

  a_high_to_vector: assert property ( // [R13]
    s_high_hit |=> above_q[$past(SMP_CH_IN)] ##1 chf_q[$past(SMP_CH_IN, 2)])
    else $error("above range sample did not reach the vector");

  a_pack_ch0_map: assert property ( // [R10]
    (int_mode_q && act_mask[0]) |=>
      (pack_q[31] == $past(below_q[0])) && (pack_q[30] == $past(above_q[0])))
    else $error("packed word channel 0 placement wrong");

  a_pack_float_zero: assert property (!int_mode_q |=> pack_q == 32'h0) // [R9]
    else $error("packed word not zero in floating mode");

  a_inactive_zero: assert property ( // [R19]
    (!comm_s && !cal_any) |=> (chf_q & ~$past(act_mask)) == 16'h0)
    else $error("inactive channel bit set in vector");

  a_apb_one_wait: assert property (
    (PSEL_IN && PENABLE_IN && !pready_q) |=> pready_q ##1 !pready_q)
    else $error("bus answer not after exactly one wait");

  a_report_follows: assert property ( // [R17]
    SMP_VLD_IN |=> rpt_vld_q && (rpt_data_q == $past(SMP_DATA_IN)))
    else $error("sample not forwarded next cycle");

endmodule

// ===== afs_fault_aggregator_tb.sv
// Register and fault word tests of the fault aggregator
`timescale 1ns/1ps
`include "afs_defs.svh"
module afs_fault_aggregator_tb;
  import afs_pkg::*;
  logic        clk, rstn, psel, penable, pwrite, comm, svld, pready, pslverr, rvld;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, packed_w, rd;
  logic [15:0] cal_busy, cal_err, sdata, rdata, mf, cf, got_data;
  logic [3:0]  sch, rch, got_ch;
  logic        err;
  int          num_errors, total_checks, got_cnt;
  logic [15:0] cal_exp [3] = '{16'hffff, 16'h00ff, 16'h000f};

  afs_fault_aggregator afs_fault_aggregator_i (.CLK_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .CAL_BUSY_IN(cal_busy),
    .CAL_ERR_IN(cal_err), .COMM_LOST_IN(comm), .SMP_VLD_IN(svld), .SMP_CH_IN(sch),
    .SMP_DATA_IN(sdata), .RPT_VLD_OUT(rvld), .RPT_CH_OUT(rch), .RPT_DATA_OUT(rdata),
    .MODULE_FAULT_OUT(mf), .CHAN_FAULT_OUT(cf), .PACKED_STATUS_OUT(packed_w));
  afs_listener_model afs_listener_model_i (.clk_in(clk), .rstn_in(rstn), .vld_in(rvld),
    .ch_in(rch), .data_in(rdata), .got_ch_out(got_ch), .got_data_out(got_data),
    .got_cnt_out(got_cnt));

  // ==========================================================
  // Clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ==========================================================
  // Shared tasks
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // One APB transfer; the request stands until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Values read just after the edge are those that stood up to it
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      $display("unexpected at %0t: no ready", $time);
      report_and_stop();
    end else begin
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // Pins pass two flops, so four edges cover the three-edge latency
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic send(input logic [3:0] c, input logic [15:0] d);
    @(posedge clk);
    svld  <= 1'b1;
    sch   <= c;
    sdata <= d;
    @(posedge clk);
    svld <= 1'b0;
    settle(3);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    num_errors   = 0;
    total_checks = 0;
    rstn         = 1'b0;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 12'h000;
    pwdata       = 32'h0;
    cal_busy     = 16'h0;
    cal_err      = 16'h0;
    comm         = 1'b0;
    svld         = 1'b0;
    sch          = 4'h0;
    sdata        = 16'h0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    // Reset values, unmapped and read-only accesses
    apb(1'b0, `AFS_OFF_LOW, 32'h0);
    chk(rd, 32'h8000, "low limit");
    apb(1'b0, `AFS_OFF_HIGH, 32'h0);
    chk(rd, 32'h7fff, "high limit");
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped err");
    apb(1'b1, `AFS_OFF_CHF, 32'hffff);
    apb(1'b0, `AFS_OFF_CHF, 32'h0);
    chk(rd, 32'h0, "ro vector");
    $display("test registers done");
    // Range limits are inclusive, mapped by channel, carried to the listener
    send(4'h2, 16'h8000);
    chk({mf, cf}, {16'h8000, 16'h0004}, "below ch2");
    chk({got_ch, got_data}, {4'h2, 16'h8000}, "listener");
    send(4'h5, 16'h7fff);
    chk(cf, 16'h0024, "above ch5");
    apb(1'b0, `AFS_OFF_CHST + 12'h008, 32'h0);
    chk(rd, 32'h40, "status ch2");
    apb(1'b1, `AFS_OFF_LOW, 32'hff00);
    send(4'h2, 16'hff00);
    send(4'h5, 16'h0000);
    chk({mf, cf}, {16'h8000, 16'h0004}, "low limit edge");
    send(4'h2, 16'hff01);
    chk({mf, cf}, 32'h0, "clear");
    $display("test range done");
    // Inactive channels in differential wiring; illegal code keeps wiring
    apb(1'b1, `AFS_OFF_CTRL, 32'h1);
    apb(1'b1, `AFS_OFF_CTRL, 32'h3);
    apb(1'b0, `AFS_OFF_CTRL, 32'h0);
    chk(rd, 32'h1, "wiring code 3");
    send(4'h9, 16'h8000);
    chk(cf, 16'h0000, "inactive ch9");
    // Calibration in every wiring format, then comm loss
    for (int w = 0; w < 3; w++) begin
      apb(1'b1, `AFS_OFF_CTRL, w);
      cal_busy <= 16'h0001;
      settle(4);
      chk({mf, cf}, {16'h8400, cal_exp[w]}, "calibrating");
      @(posedge clk);
      cal_busy <= 16'h0000;
      settle(4);
      chk(cf, 16'h0000, "cal over");
    end
    @(posedge clk);
    comm <= 1'b1;
    settle(4);
    chk({mf, cf}, {16'h8000, 16'hffff}, "comm lost hsdiff");
    @(posedge clk);
    comm <= 1'b0;
    $display("test calibration done");
    // Integer mode: packed word and module calibration fault
    apb(1'b1, `AFS_OFF_CTRL, 32'h4);
    apb(1'b1, `AFS_OFF_LOW, 32'h8000);
    cal_err <= 16'h0002;
    settle(4);
    chk({mf, cf}, {16'h0200, 16'h0000}, "cal error int");
    @(posedge clk);
    cal_err <= 16'h0000;
    send(4'h0, 16'h8000);
    send(4'hf, 16'h7fff);
    send(4'h1, 16'h7fff);
    chk(packed_w, 32'h90000001, "packed");
    chk(cf, 16'h8003, "int vector");
    apb(1'b0, `AFS_OFF_PACK, 32'h0);
    chk(rd, 32'h90000001, "packed reg");
    apb(1'b0, `AFS_OFF_CHST, 32'h0);
    chk(rd, 32'h0, "status int");
    apb(1'b1, `AFS_OFF_CTRL, 32'h0);
    settle(3);
    chk(packed_w, 32'h0, "packed float");
    chk(got_cnt, 32'd9, "sample count");
    $display("test integer done");
    report_and_stop();
  end
endmodule

// ===== afs_listener_model.sv
// Listening controller model that captures every forwarded sample
`timescale 1ns/1ps
module afs_listener_model (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        vld_in,
  input  wire logic [3:0]  ch_in,
  input  wire logic [15:0] data_in,
  output logic      [3:0]  got_ch_out,
  output logic      [15:0] got_data_out,
  output int               got_cnt_out
);
  // ==========================================================
  // Capture
  // No back-pressure exists on this path, so every valid cycle is taken
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      got_cnt_out  <= 0;
      got_ch_out   <= 4'h0;
      got_data_out <= 16'h0000;
    end else if (vld_in) begin
      got_cnt_out  <= got_cnt_out + 1;
      got_ch_out   <= ch_in;
      got_data_out <= data_in;
    end
  end
endmodule

// ===== afs_pkg.sv
// Types shared by the fault aggregator
package afs_pkg;
  // Wiring format; the fourth code is illegal and never stored
  typedef enum logic [1:0] {
    AFS_WIRE_SE,
    AFS_WIRE_DIFF,
    AFS_WIRE_HSDIFF
  } afs_wiring_type;
endpackage
